// File: src/cic_pkg.sv
// constants, register map and types for the cpu interrupt controller
package cic_pkg;
  localparam int unsigned NVEC = 32;
  localparam int unsigned VW = 8;
  localparam int unsigned AW = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] IDX_IRQ_EXECUTING_FLAGS = 8'h01;
  localparam logic [7:0] IDX_NORMAL_PRIORITY_POINTER = 8'h02;
  localparam logic [7:0] IDX_HIGH_PRIORITY_VECTOR = 8'h03;
  localparam int unsigned REG_ADDR_LSB = 2;
  localparam int unsigned REG_IDX_BITS = 8;
  // field positions
  localparam int unsigned CTRL_PLACE_BIT = 6;
  localparam int unsigned CTRL_COMPACT_BIT = 5;
  localparam int unsigned CTRL_RR_BIT = 0;
  localparam int unsigned STAT_NMI_BIT = 7;
  localparam int unsigned STAT_L1_BIT = 1;
  localparam int unsigned STAT_L0_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PRI_RESET = 8'h00;
  localparam logic [7:0] L1VEC_RESET = 8'h00;
  localparam logic [7:0] L1VEC_OFF = 8'h00;
  // compact table slots
  localparam logic [7:0] CVT_NMI_VEC = 8'h01;
  localparam logic [7:0] CVT_L1_VEC = 8'h02;
  localparam logic [7:0] CVT_L0_VEC = 8'h03;
  // non-maskable sources are fixed per device; vector 1 here
  localparam logic [NVEC-1:0] NMI_MASK = 32'h0000_0002;
  // words per vector slot and flash block size of the boot-end fuse
  localparam int unsigned VEC_WORD_SHIFT = 1;
  localparam int unsigned BOOT_BLOCK_SHIFT = 7;
  // protection window length in cpu instructions
  localparam logic [2:0] CCP_WINDOW = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LVL_NONE, LVL_NORMAL, LVL_HIGH, LVL_NMI} cic_level_e;
endpackage

// File: src/cic_arbiter.sv
// lowest-vector-first picker with optional rotation start point
`timescale 1ns/10ps
module cic_arbiter
  import cic_pkg::*;
(
  input wire logic [NVEC-1:0] req_i,
  input wire logic [VW-1:0] last_i,
  input wire logic rotate_i,
  output logic any_o,
  output logic [VW-1:0] vec_o
);
  logic [NVEC-1:0] above;
  logic [NVEC-1:0] hi_req;
  logic [VW-1:0] lo_pick;
  logic [VW-1:0] hi_pick;

  // vectors above the last served one go first when rotating
  genvar g;
  generate
    for (g = 0; g < NVEC; g++) begin : g_above
      assign above[g] = rotate_i && (VW'(g) > last_i);
    end
  endgenerate

  assign hi_req = req_i & above;

  always_comb begin
    lo_pick = '0;
    hi_pick = '0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        lo_pick = VW'(i);
      end
      if (hi_req[i]) begin
        hi_pick = VW'(i);
      end
    end
    any_o = |req_i;
    vec_o = (|hi_req) ? hi_pick : lo_pick;
  end
endmodule

// File: src/cic_top.sv
// cpu interrupt controller: axi4-lite registers, level tracking, vector offer
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// How it works
// - control bit 6 puts the vector table at the application area start when 0, boot area when 1.
// - control bit 5 turns the compact vector table off when 0 and on when 1.
// - in compact mode non-maskable uses vector 1, level 1 uses 2, all level 0 share 3.
// - bits 6 and 5 change only inside the protection window; bit 0 is always writable.
// - with round robin off, the lowest pending level-0 vector wins.
// - with round robin on, the last acknowledged level-0 vector is stored and ranks last next time.
// - reset clears the level-0 pointer so the lowest vector ranks highest again.
// - status bit 7 is set while a non-maskable handler runs and cleared by its return.
// - status bit 1 is set while a level-1 handler runs, even when pre-empted, until its return.
// - status bit 0 is set while a level-0 handler runs, even when pre-empted, until its return.
// - the source whose vector equals the high-priority vector register outranks all level 0.
// - a zero high-priority vector register promotes no source.
// - a level-1 request pre-empts a level-0 handler, which resumes after the level-1 return.
// - nothing interrupts a non-maskable handler; simultaneous ones go lowest vector first.
module cic_top
  import cic_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NVEC-1:0] irq_req_i,
  input wire logic global_irq_enable_i,
  input wire logic ccp_unlock_i,
  input wire logic cpu_instr_done_i,
  input wire logic irq_ack_i,
  input wire logic return_from_handler_i,
  input wire logic [7:0] boot_area_end_fuse_i,
  output logic irq_valid_o,
  output logic [VW-1:0] irq_vector_o,
  output logic [AW-1:0] irq_addr_o,
  output logic [1:0] irq_level_o
);
  //////////////////////////////////////////////////////////////////////////
  // state
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic place_r, place_nxt, compact_r, compact_nxt, rr_r, rr_nxt;
  logic [7:0] pri_r, pri_nxt, l1vec_r, l1vec_nxt;
  logic [2:0] ccp_cnt_r, ccp_cnt_nxt;
  logic nmi_ex_r, nmi_ex_nxt, l1_ex_r, l1_ex_nxt, l0_ex_r, l0_ex_nxt;
  logic valid_r, valid_nxt;
  logic [VW-1:0] vec_r, vec_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  cic_level_e lvl_r, lvl_nxt;
  logic do_write;
  logic [REG_IDX_BITS-1:0] widx, ridx;
  logic [7:0] ctrl_rd, stat_rd;
  logic [NVEC-1:0] nmi_req, l1_bit, l0_req;
  logic nmi_any, l0_any;
  logic [VW-1:0] nmi_vec, l0_vec;
  logic ack_hit;
  //////////////////////////////////////////////////////////////////////////
  // axi4-lite slave; write address and data taken in either order
  assign do_write = !awready_r && !wready_r && !bvalid_r;
  assign widx = REG_IDX_BITS'(awaddr_r >> REG_ADDR_LSB);
  assign ridx = REG_IDX_BITS'(s_axi_araddr >> REG_ADDR_LSB);
  assign ctrl_rd = {1'b0, place_r, compact_r, 4'h0, rr_r};
  assign stat_rd = {nmi_ex_r, 5'h00, l1_ex_r, l0_ex_r};
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awready_r && s_axi_awvalid) begin
      awready_nxt = 1'b0;
      awaddr_nxt = s_axi_awaddr;
    end
    if (wready_r && s_axi_wvalid) begin
      wready_nxt = 1'b0;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (widx <= IDX_HIGH_PRIORITY_VECTOR) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (arready_r && s_axi_arvalid) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (ridx)
        IDX_IRQ_CONTROL: rdata_nxt = {24'h000000, ctrl_rd};
        IDX_IRQ_EXECUTING_FLAGS: rdata_nxt = {24'h000000, stat_rd};
        IDX_NORMAL_PRIORITY_POINTER: rdata_nxt = {24'h000000, pri_r};
        IDX_HIGH_PRIORITY_VECTOR: rdata_nxt = {24'h000000, l1vec_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // configuration registers and protection window
  assign ack_hit = irq_ack_i && valid_r;
  always_comb begin
    place_nxt = place_r;
    compact_nxt = compact_r;
    rr_nxt = rr_r;
    pri_nxt = pri_r;
    l1vec_nxt = l1vec_r;
    ccp_cnt_nxt = ccp_cnt_r;
    // the window counts retired instructions, not clocks
    if (ccp_cnt_r != 3'h0 && cpu_instr_done_i) begin
      ccp_cnt_nxt = ccp_cnt_r - 3'h1;
    end
    if (ccp_unlock_i) begin
      ccp_cnt_nxt = CCP_WINDOW;
    end
    if (do_write && wstrb_r[0]) begin
      unique case (widx)
        IDX_IRQ_CONTROL: begin
          rr_nxt = wdata_r[CTRL_RR_BIT];
          if (ccp_cnt_r != 3'h0) begin
            place_nxt = wdata_r[CTRL_PLACE_BIT];
            compact_nxt = wdata_r[CTRL_COMPACT_BIT];
          end
        end
        IDX_NORMAL_PRIORITY_POINTER: pri_nxt = wdata_r[7:0];
        IDX_HIGH_PRIORITY_VECTOR: l1vec_nxt = wdata_r[7:0];
        default: ;
      endcase
    end
    // hardware update beats a same-cycle software write
    if (ack_hit && lvl_r == LVL_NORMAL && rr_r) begin
      pri_nxt = vec_r;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      place_r <= CTRL_RESET[CTRL_PLACE_BIT];
      compact_r <= CTRL_RESET[CTRL_COMPACT_BIT];
      rr_r <= CTRL_RESET[CTRL_RR_BIT];
      pri_r <= PRI_RESET;
      l1vec_r <= L1VEC_RESET;
      ccp_cnt_r <= 3'h0;
    end else begin
      place_r <= place_nxt;
      compact_r <= compact_nxt;
      rr_r <= rr_nxt;
      pri_r <= pri_nxt;
      l1vec_r <= l1vec_nxt;
      ccp_cnt_r <= ccp_cnt_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // executing flags: ack of an offered level sets, return clears the innermost
  always_comb begin
    nmi_ex_nxt = nmi_ex_r;
    l1_ex_nxt = l1_ex_r;
    l0_ex_nxt = l0_ex_r;
    if (return_from_handler_i) begin
      if (nmi_ex_r) begin
        nmi_ex_nxt = 1'b0;
      end else if (l1_ex_r) begin
        l1_ex_nxt = 1'b0;
      end else begin
        l0_ex_nxt = 1'b0;
      end
    end
    if (ack_hit) begin
      unique case (lvl_r)
        LVL_NMI: nmi_ex_nxt = 1'b1;
        LVL_HIGH: l1_ex_nxt = 1'b1;
        LVL_NORMAL: l0_ex_nxt = 1'b1;
        LVL_NONE: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      nmi_ex_r <= 1'b0;
      l1_ex_r <= 1'b0;
      l0_ex_r <= 1'b0;
    end else begin
      nmi_ex_r <= nmi_ex_nxt;
      l1_ex_r <= l1_ex_nxt;
      l0_ex_r <= l0_ex_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // request selection
  assign nmi_req = irq_req_i & NMI_MASK;
  assign l1_bit = (l1vec_r == L1VEC_OFF) ? '0 : (NVEC'(1) << l1vec_r);
  assign l0_req = irq_req_i & ~NMI_MASK & ~l1_bit;
  cic_arbiter u_nmi_arb (
    .req_i(nmi_req),
    .last_i(8'h00),
    .rotate_i(1'b0),
    .any_o(nmi_any),
    .vec_o(nmi_vec)
  );
  cic_arbiter u_l0_arb (
    .req_i(l0_req),
    .last_i(pri_r),
    .rotate_i(rr_r),
    .any_o(l0_any),
    .vec_o(l0_vec)
  );
  // offer is registered; it drops for a cycle after any ack or return so a
  // stale offer is never taken twice
  always_comb begin
    logic [AW-1:0] base;
    logic [VW-1:0] slot;
    base = '0;
    slot = '0;
    valid_nxt = 1'b0;
    vec_nxt = vec_r;
    lvl_nxt = LVL_NONE;
    if (nmi_ex_r) begin
      valid_nxt = 1'b0;
    end else if (nmi_any) begin
      valid_nxt = 1'b1;
      vec_nxt = nmi_vec;
      lvl_nxt = LVL_NMI;
    end else if (global_irq_enable_i && !l1_ex_r && (|(irq_req_i & l1_bit))) begin
      valid_nxt = 1'b1;
      vec_nxt = l1vec_r;
      lvl_nxt = LVL_HIGH;
    end else if (global_irq_enable_i && !l1_ex_r && !l0_ex_r && l0_any) begin
      valid_nxt = 1'b1;
      vec_nxt = l0_vec;
      lvl_nxt = LVL_NORMAL;
    end
    if (irq_ack_i || return_from_handler_i) begin
      valid_nxt = 1'b0;
      lvl_nxt = LVL_NONE;
    end
    slot = vec_nxt;
    if (compact_r) begin
      unique case (lvl_nxt)
        LVL_NMI: slot = CVT_NMI_VEC;
        LVL_HIGH: slot = CVT_L1_VEC;
        LVL_NORMAL: slot = CVT_L0_VEC;
        LVL_NONE: slot = vec_nxt;
      endcase
    end
    if (!place_r) begin
      base = AW'({boot_area_end_fuse_i, {BOOT_BLOCK_SHIFT{1'b0}}});
    end
    addr_nxt = AW'(base + AW'({slot, {VEC_WORD_SHIFT{1'b0}}}));
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      valid_r <= 1'b0;
      vec_r <= '0;
      addr_r <= '0;
      lvl_r <= LVL_NONE;
    end else begin
      valid_r <= valid_nxt;
      vec_r <= vec_nxt;
      addr_r <= addr_nxt;
      lvl_r <= lvl_nxt;
    end
  end
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign irq_valid_o = valid_r;
  assign irq_vector_o = vec_r;
  assign irq_addr_o = addr_r;
  assign irq_level_o = lvl_r;
endmodule

// File: verif/cic_monitor.sv
// port assertions for the cpu interrupt controller
`timescale 1ns/10ps
module cic_monitor
  import cic_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [NVEC-1:0] irq_req_i,
  input wire logic irq_ack_i,
  input wire logic return_from_handler_i,
  input wire logic irq_valid_o,
  input wire logic [VW-1:0] irq_vector_o,
  input wire logic [1:0] irq_level_o,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  // nesting mirror: bit 2 nmi, bit 1 high, bit 0 normal
  logic [2:0] f_r;
  logic [2:0] f_nxt;
  always_comb begin
    f_nxt = f_r;
    if (return_from_handler_i) begin
      if (f_r[2]) f_nxt[2] = 1'h0;
      else if (f_r[1]) f_nxt[1] = 1'h0;
      else f_nxt[0] = 1'h0;
    end
    if (irq_ack_i && irq_valid_o) f_nxt[irq_level_o - 2'h1] = 1'h1;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) f_r <= 3'h0;
    else f_r <= f_nxt;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_nmi_not_preempted: assert property (f_r[2] |-> !irq_valid_o)
    else $error("offer during nmi handler");
  chk_high_blocks_low: assert property (f_r[1] |-> !(irq_valid_o && irq_level_o != 2'h3))
    else $error("level 0 or 1 offer during high handler");
  chk_normal_blocks_normal: assert property (f_r[0] |-> !(irq_valid_o && irq_level_o == 2'h1))
    else $error("normal offer during normal handler");
  chk_ack_drops_offer: assert property (irq_ack_i && irq_valid_o |=> !irq_valid_o)
    else $error("offer kept after ack");
  chk_nmi_vector_one: assert property (irq_valid_o && irq_level_o == 2'h3 |-> irq_vector_o == 8'h01)
    else $error("nmi offer with wrong vector");
  chk_offer_has_req: assert property (
    irq_valid_o |-> |($past(irq_req_i) & (32'h1 << irq_vector_o)))
    else $error("offer without request");
  chk_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_reset_quiet: assert property ($past(sys_rst_i) |-> !irq_valid_o)
    else $error("offer right after reset");
  cover property (irq_ack_i && irq_valid_o && irq_level_o == 2'h3);
  cover property (irq_ack_i && irq_valid_o && irq_level_o == 2'h2);
  cover property (irq_ack_i && irq_valid_o && irq_level_o == 2'h1);
endmodule
bind cic_top cic_monitor u_mon (.clk_i, .sys_rst_i, .irq_req_i, .irq_ack_i,
  .return_from_handler_i, .irq_valid_o, .irq_vector_o, .irq_level_o, .s_axi_rdata, .s_axi_rvalid);

// File: verif/cic_cpu_model.sv
// cpu core model: takes a standing vector offer when allowed
`timescale 1ns/10ps
module cic_cpu_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic irq_valid_i,
  input wire logic take_en_i,
  output logic irq_ack_o
);
  logic ack_nxt;
  // one pulse per offer; the guard stops a second take of the same offer
  always_comb ack_nxt = take_en_i && irq_valid_i && !irq_ack_o;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) irq_ack_o <= 1'h0;
    else irq_ack_o <= ack_nxt;
  end
endmodule

// File: verif/tb.sv
// self-checking bench for the cpu interrupt controller
`timescale 1ns/10ps
module tb
  import cic_pkg::*;
;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, boot_area_end_fuse_i = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, ccp_unlock_i = 0, cpu_instr_done_i = 0, return_from_handler_i = 0;
  logic global_irq_enable_i = 1'h1, take = 0;
  logic [31:0] s_axi_wdata = '0, seed = 32'hd88a;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [NVEC-1:0] irq_req_i = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_valid_o, irq_ack_i;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_level_o;
  logic [VW-1:0] irq_vector_o;
  logic [AW-1:0] irq_addr_o, base;
  int err_count = 0, tests_run = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [25:0] iq[$];
  always #2 clk_i = ~clk_i;
  cic_top dut (.clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req_i, .global_irq_enable_i,
    .ccp_unlock_i, .cpu_instr_done_i, .irq_ack_i, .return_from_handler_i,
    .boot_area_end_fuse_i, .irq_valid_o, .irq_vector_o, .irq_addr_o, .irq_level_o);
  cic_cpu_model cpu (.clk_i, .sys_rst_i, .irq_valid_i(irq_valid_o), .take_en_i(take),
    .irq_ack_o(irq_ack_i));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // a result with no note left is a mismatch too
  task automatic cmp_rd(input logic [33:0] g);
    cmp("rd", rq.size() ? rq.pop_front() : 34'hx, g);
  endtask
  task automatic cmp_wr(input logic [1:0] g);
    cmp("bresp", bq.size() ? bq.pop_front() : 2'hx, g);
  endtask
  task automatic cmp_irq(input logic [25:0] g);
    cmp("offer", iq.size() ? iq.pop_front() : 26'hx, g);
  endtask
  task automatic end_sim;
    err_count += rq.size() + bq.size() + iq.size();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watcher: each result takes the oldest note of its kind
  always @(posedge clk_i) begin
    if (s_axi_rvalid && s_axi_rready) cmp_rd({s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp_wr(s_axi_bresp);
    if (irq_ack_i && irq_valid_o) cmp_irq({irq_vector_o, irq_level_o, irq_addr_o});
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    bq.push_back(er);
    s_axi_awaddr <= idx << 2;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    rq.push_back({er, 24'h0, d});
    s_axi_araddr <= idx << 2;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'h0;
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  // raise requests, let the core take after a random delay, then drop them
  task automatic irq(input logic [31:0] m, input logic [7:0] v, input logic [1:0] l,
      input logic [15:0] a);
    int n;
    iq.push_back({v, l, a});
    irq_req_i <= m;
    seed = xs(seed);
    repeat (seed[1:0]) @(posedge clk_i);
    take <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (iq.size() != 0 && n < 40);
    take <= 1'h0;
    irq_req_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      if (k == 0) ccp_unlock_i <= 1'h1;
      if (k == 1) cpu_instr_done_i <= 1'h1;
      if (k == 2) return_from_handler_i <= 1'h1;
      @(posedge clk_i);
      {ccp_unlock_i, cpu_instr_done_i, return_from_handler_i} <= 3'h0;
      @(posedge clk_i);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    seed = xs(seed);
    boot_area_end_fuse_i <= seed[7:0];
    base = {1'h0, seed[7:0], 7'h0};
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 5; i++) rd(i[7:0], 8'h00, i < 4 ? RESP_OKAY : RESP_SLVERR);
    wr(8'h04, 8'h5a, RESP_SLVERR);
    wr(8'h00, 8'hff, RESP_OKAY);
    rd(8'h00, 8'h01, RESP_OKAY);
    wr(8'h01, 8'hff, RESP_OKAY);
    rd(8'h01, 8'h00, RESP_OKAY);
    pulse(0, 1);
    pulse(1, 4);
    wr(8'h00, 8'h60, RESP_OKAY);
    rd(8'h00, 8'h00, RESP_OKAY);
    pulse(0, 1);
    pulse(1, 3);
    wr(8'h00, 8'h60, RESP_OKAY);
    rd(8'h00, 8'h60, RESP_OKAY);
    seed = xs(seed);
    wr(8'h03, seed[15:8], RESP_OKAY);
    rd(8'h03, seed[15:8], RESP_OKAY);
    wr(8'h03, 8'h07, RESP_OKAY);
    // a write with its low byte strobe off must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(8'h03, 8'h11, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(8'h03, 8'h07, RESP_OKAY);
    // compact table at boot area: slots 3, 2, 1 of two words each
    irq(32'h20, 8'h05, 2'h1, 16'h0006);
    irq(32'h80, 8'h07, 2'h2, 16'h0004);
    // non-maskable is served with the global enable off
    global_irq_enable_i <= 1'h0;
    irq(32'h02, 8'h01, 2'h3, 16'h0002);
    global_irq_enable_i <= 1'h1;
    rd(8'h01, 8'h83, RESP_OKAY);
    pulse(2, 1);
    rd(8'h01, 8'h03, RESP_OKAY);
    pulse(2, 1);
    rd(8'h01, 8'h01, RESP_OKAY);
    pulse(2, 1);
    rd(8'h01, 8'h00, RESP_OKAY);
    pulse(0, 1);
    wr(8'h00, 8'h01, RESP_OKAY);
    wr(8'h03, 8'h00, RESP_OKAY);
    irq(32'h80, 8'h07, 2'h1, base + 16'h000e);
    pulse(2, 1);
    irq(32'h48, 8'h03, 2'h1, base + 16'h0006);
    pulse(2, 1);
    rd(8'h02, 8'h03, RESP_OKAY);
    wr(8'h00, 8'h00, RESP_OKAY);
    irq(32'h48, 8'h03, 2'h1, base + 16'h0006);
    pulse(2, 1);
    wr(8'h00, 8'h01, RESP_OKAY);
    irq(32'h48, 8'h06, 2'h1, base + 16'h000c);
    pulse(2, 1);
    rd(8'h02, 8'h06, RESP_OKAY);
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    rd(8'h02, 8'h00, RESP_OKAY);
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule
